//--- rtl/sla_core.sv
// Shift-left with add, subtract or product-only datapath slice
`timescale 1ns/1ps
module sla_core
  import sla_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                RST,
  input  wire logic                START,
  input  wire sla_op_e             OP,
  input  wire sla_amode_e          AMODE,
  input  wire sla_mod_e            NEXT_MOD,
  input  wire logic [1:0]          PTR_SEL,
  input  wire logic                SRC_ALT,
  input  wire logic                DST_ALT,
  input  wire logic [WORD_W-1:0]   SECOND_WORD,
  input  wire logic [WORD_W-1:0]   ADDR_REG,
  input  wire logic [WORD_W-1:0]   INDEX_REG,
  input  wire logic [3:0]          STRING_COUNT,
  input  wire logic [SV_W-1:0]     SHIFT_AMOUNT_REG,
  input  wire logic                SIGN_EXTEND_MODE_BIT,
  output logic                     MEM_RD,
  output logic      [WORD_W-1:0]   MEM_ADDR,
  input  wire logic [WORD_W-1:0]   MEM_RDATA,
  input  wire logic                MEM_TAG,
  output logic                     ADDR_WR,
  output logic      [WORD_W-1:0]   ADDR_WR_DATA,
  input  wire logic                ACC_WR_EN,
  input  wire logic [ACC_IDXW-1:0] ACC_WR_IDX,
  input  wire logic [WORD_W-1:0]   ACC_WR_DATA,
  input  wire logic [ACC_IDXW-1:0] ACC_RD_IDX,
  output logic      [WORD_W-1:0]   ACC_RD_DATA,
  output logic      [PTR_W-1:0]    ACCUM_POINTER_ONE,
  output logic                     BUSY,
  output logic                     DONE,
  output logic      [WORD_W-1:0]   SHIFT_HIGH_REG,
  output logic                     OVERFLOW_FLAG,
  output logic                     SIGN_FLAG,
  output logic                     ZERO_FLAG,
  output logic                     CARRY_FLAG,
  output logic                     TAG_FLAG
);

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_FINISH} sla_state_e;

  sla_state_e          state_r;
  logic [WORD_W-1:0]   acc_r [ACC_N];
  logic [PTR_W-1:0]    ptr_r [PTR_N];
  sla_op_e             op_r;
  sla_amode_e          amode_r;
  logic [PTR_W-1:0]    base_r;
  logic                src_alt_r, dst_alt_r;
  logic [CNT_W-1:0]    len_r, idx_r;
  logic [SV_W-1:0]     sv_r;
  logic                xm_r;
  logic [WORD_W-1:0]   addr_r, addr_post_r;
  logic [WORD_W-1:0]   shcarry_r;
  logic                acarry_r, zero_acc_r, ovf_r;
  logic [WORD_W-1:0]   last_res_r;

  logic                mem_src, is_sub, last_word, writes_acc;
  logic [PTR_W-1:0]    ptr_mod;
  logic [ACC_IDXW-1:0] src_idx, dst_idx;
  logic [WORD_W-1:0]   operand, sh_low, sh_high, dst_val, addend, res;
  logic [WORD_W:0]     sum;
  logic                ovf_nxt;

  assign mem_src    = (amode_r != AM_ACC);
  assign is_sub     = (op_r == OP_SUB_WORD) || (op_r == OP_SUB_STR);
  assign writes_acc = (op_r != OP_STR_PROD);
  assign last_word  = (idx_r == len_r - WORD_LEN);
  assign src_idx    = {src_alt_r, 4'(base_r + idx_r[PTR_W-1:0])};
  assign dst_idx    = {dst_alt_r, 4'(base_r + idx_r[PTR_W-1:0])};
  assign operand    = mem_src ? MEM_RDATA : acc_r[src_idx];

  // Pre-step of the selected pointer, taken before the operand is read
  always_comb begin
    unique case (NEXT_MOD)
      MOD_INC: ptr_mod = ptr_r[PTR_SEL] + 4'h1;
      MOD_DEC: ptr_mod = ptr_r[PTR_SEL] - 4'h1;
      default: ptr_mod = ptr_r[PTR_SEL];
    endcase
  end

  // ----------------------------------------------------------------
  // Shift and add or subtract
  // ----------------------------------------------------------------
  sla_shift u_shift (
    .word_in  (operand),
    .amount   (sv_r),
    .carry_in (shcarry_r),
    .extend   (xm_r & last_word),
    .low_out  (sh_low),
    .high_out (sh_high)
  );

  assign dst_val = acc_r[dst_idx];
  assign addend  = is_sub ? ~sh_low : sh_low;
  assign sum     = {1'b0, dst_val} + {1'b0, addend} + {16'h0000, acarry_r};
  assign res     = writes_acc ? sum[WORD_W-1:0] : sh_low;
  assign ovf_nxt = writes_acc && (dst_val[WORD_W-1] == addend[WORD_W-1])
                   && (sum[WORD_W-1] != dst_val[WORD_W-1]);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:   if (START) state_r <= ST_FETCH;
        ST_FETCH:  state_r <= ST_EXEC;
        ST_EXEC:   state_r <= last_word ? ST_FINISH : ST_FETCH;
        ST_FINISH: state_r <= ST_IDLE;
      endcase
    end
  end

  // Instruction capture; operands are held steady for the whole string
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      op_r      <= OP_ADD_WORD;
      amode_r   <= AM_ACC;
      base_r    <= PTR_RST;
      src_alt_r <= 1'b0;
      dst_alt_r <= 1'b0;
      len_r     <= WORD_LEN;
      sv_r      <= '0;
      xm_r      <= 1'b0;
    end else if (state_r == ST_IDLE && START) begin
      op_r      <= OP;
      amode_r   <= AMODE;
      base_r    <= ptr_mod;
      src_alt_r <= SRC_ALT;
      dst_alt_r <= DST_ALT;
      sv_r      <= SHIFT_AMOUNT_REG;
      xm_r      <= SIGN_EXTEND_MODE_BIT;
      if (OP == OP_ADD_STR || OP == OP_SUB_STR || OP == OP_STR_PROD) begin
        len_r <= {1'b0, STRING_COUNT} + STR_EXTRA;
      end else begin
        len_r <= WORD_LEN;
      end
    end
  end

  // Accumulator pointers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int k = 0; k < PTR_N; k++) ptr_r[k] <= PTR_RST;
    end else if (state_r == ST_IDLE && START) begin
      ptr_r[PTR_SEL] <= ptr_mod;
    end
  end

  // Memory address: second word is a direct address or a long offset
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      addr_r      <= WORD_RST;
      addr_post_r <= WORD_RST;
    end else if (state_r == ST_IDLE && START) begin
      unique case (AMODE)
        AM_DIRECT:   addr_r <= SECOND_WORD;
        AM_LONG_REL: addr_r <= ADDR_REG + SECOND_WORD;
        default:     addr_r <= ADDR_REG;
      endcase
      addr_post_r <= (AMODE == AM_POST_ADD) ? ADDR_REG + INDEX_REG
                                            : ADDR_REG + ADDR_STEP;
    end else if (state_r == ST_EXEC) begin
      addr_r <= addr_r + ADDR_STEP;
    end
  end

  // Per-word chain state: shifted-out bits, arithmetic carry, zero and overflow
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      shcarry_r  <= WORD_RST;
      acarry_r   <= 1'b0;
      zero_acc_r <= 1'b1;
      ovf_r      <= 1'b0;
      last_res_r <= WORD_RST;
      idx_r      <= '0;
    end else if (state_r == ST_IDLE && START) begin
      shcarry_r  <= WORD_RST;
      acarry_r   <= (OP == OP_SUB_WORD || OP == OP_SUB_STR);
      zero_acc_r <= 1'b1;
      idx_r      <= '0;
    end else if (state_r == ST_EXEC) begin
      shcarry_r  <= sh_high;
      acarry_r   <= sum[WORD_W];
      zero_acc_r <= zero_acc_r & (res == WORD_RST);
      ovf_r      <= ovf_nxt;
      last_res_r <= res;
      idx_r      <= idx_r + WORD_LEN;
    end
  end

  // Accumulator file: loaded from outside only while the datapath is idle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int k = 0; k < ACC_N; k++) acc_r[k] <= WORD_RST;
    end else if (state_r == ST_EXEC && writes_acc) begin
      acc_r[dst_idx] <= sum[WORD_W-1:0];
    end else if (state_r == ST_IDLE && ACC_WR_EN) begin
      acc_r[ACC_WR_IDX] <= ACC_WR_DATA;
    end
  end

  // High register and flags; the last word's upper half is the extension
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SHIFT_HIGH_REG <= WORD_RST;
      OVERFLOW_FLAG  <= 1'b0;
      SIGN_FLAG      <= 1'b0;
      ZERO_FLAG      <= 1'b0;
      CARRY_FLAG     <= 1'b0;
    end else if (state_r == ST_FINISH) begin
      SHIFT_HIGH_REG <= shcarry_r;
      OVERFLOW_FLAG  <= ovf_r;
      SIGN_FLAG      <= last_res_r[WORD_W-1];
      ZERO_FLAG      <= zero_acc_r;
      CARRY_FLAG     <= writes_acc ? acarry_r : (shcarry_r != WORD_RST);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TAG_FLAG <= 1'b0;
    end else if (state_r == ST_EXEC && mem_src && last_word) begin
      TAG_FLAG <= MEM_TAG;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ADDR_WR      <= 1'b0;
      ADDR_WR_DATA <= WORD_RST;
      DONE         <= 1'b0;
    end else begin
      ADDR_WR      <= (state_r == ST_FINISH)
                      && (amode_r == AM_POST_ADD || amode_r == AM_POST_INC);
      ADDR_WR_DATA <= addr_post_r;
      DONE         <= (state_r == ST_FINISH);
    end
  end

  assign MEM_RD            = (state_r == ST_FETCH) && mem_src;
  assign MEM_ADDR          = addr_r;
  assign ACC_RD_DATA       = acc_r[ACC_RD_IDX];
  assign ACCUM_POINTER_ONE = ptr_r[1];
  assign BUSY              = (state_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_high_latch: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_FINISH |=> SHIFT_HIGH_REG == $past(shcarry_r))
    else $error("high register not loaded from shift");

  a_word_add: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_EXEC && op_r == OP_ADD_WORD
    |=> acc_r[$past(dst_idx)] == $past(dst_val) + $past(sh_low))
    else $error("word add result wrong");

  a_word_sub: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_EXEC && op_r == OP_SUB_WORD
    |=> acc_r[$past(dst_idx)] == $past(dst_val) - $past(sh_low))
    else $error("word subtract result wrong");

  a_amount_use: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_IDLE && START |=> sv_r == $past(SHIFT_AMOUNT_REG))
    else $error("shift amount not taken from register");

  a_zero_shift: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_EXEC && sv_r == 4'h0 && idx_r == '0 |-> sh_low == operand)
    else $error("zero shift altered operand");

  a_string_len: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_IDLE && START && OP == OP_STR_PROD
    |=> len_r == $past(STRING_COUNT) + STR_EXTRA)
    else $error("string length not count plus two");

  a_prod_keep: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_EXEC && op_r == OP_STR_PROD
    |=> acc_r[$past(dst_idx)] == $past(dst_val))
    else $error("product-only form wrote an accumulator");

  a_post_inc: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_IDLE && START && AMODE == AM_POST_INC && (OP == OP_ADD_WORD || OP == OP_SUB_WORD)
    |-> ##4 ADDR_WR && ADDR_WR_DATA == $past(ADDR_REG, 4) + ADDR_STEP)
    else $error("post increment not by two");

  a_pre_step: assert property (@(posedge MCLK) disable iff (RST)
    state_r == ST_IDLE && START && NEXT_MOD == MOD_INC
    |=> ptr_r[$past(PTR_SEL)] == $past(ptr_r[PTR_SEL]) + 4'h1)
    else $error("pointer pre-increment missing");

  a_done_flags: assert property (@(posedge MCLK) disable iff (RST)
    DONE |-> ZERO_FLAG == $past(zero_acc_r) && SIGN_FLAG == $past(last_res_r[WORD_W-1]))
    else $error("flags not taken from result");

endmodule : sla_core

//--- rtl/sla_pkg.sv
// Shared constants and types of the shift-left accumulate datapath
package sla_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned ACC_IDXW = 5;
  localparam int unsigned ACC_N    = 32;
  localparam int unsigned PTR_W    = 4;
  localparam int unsigned PTR_N    = 4;
  localparam int unsigned SV_W     = 4;
  localparam int unsigned CNT_W    = 5;

  // ----------------------------------------------------------------
  // Counts, steps and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0]      ADDR_STEP  = 16'h0002;
  localparam logic [CNT_W-1:0] STR_EXTRA  = 5'h02;
  localparam logic [CNT_W-1:0] WORD_LEN   = 5'h01;
  localparam logic [PTR_W-1:0] PTR_RST    = 4'h0;
  localparam logic [15:0]      WORD_RST   = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ADD_WORD, OP_ADD_STR, OP_SUB_WORD, OP_SUB_STR, OP_STR_PROD
  } sla_op_e;

  typedef enum logic [2:0] {
    AM_ACC, AM_DIRECT, AM_LONG_REL, AM_POST_ADD, AM_POST_INC
  } sla_amode_e;

  typedef enum logic [1:0] {
    MOD_NONE, MOD_INC, MOD_DEC
  } sla_mod_e;

endpackage : sla_pkg

//--- rtl/sla_shift.sv
// One word step of the left shifter with carry-in of the bits from the word below
`timescale 1ns/1ps
module sla_shift
  import sla_pkg::*;
(
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic [SV_W-1:0]   amount,
  input  wire logic [WORD_W-1:0] carry_in,
  input  wire logic              extend,
  output logic      [WORD_W-1:0] low_out,
  output logic      [WORD_W-1:0] high_out
);
  logic [2*WORD_W-1:0] wide;

  // Zero fill on the right; left fill is sign only when asked, else zero
  always_comb begin
    wide     = {(extend ? {WORD_W{word_in[WORD_W-1]}} : {WORD_W{1'b0}}), word_in} << amount;
    low_out  = wide[WORD_W-1:0] | carry_in;
    high_out = wide[2*WORD_W-1:WORD_W];
  end

endmodule : sla_shift

//--- sim/sla_core_test.sv
// Self-checking bench of the shift-left accumulate datapath
`timescale 1ns/1ps
module sla_core_test
  import sla_pkg::*;
;
  logic             MCLK = 1'b0;
  logic             RST  = 1'b1;
  logic             start = 1'b0;
  sla_op_e          op    = OP_ADD_WORD;
  sla_amode_e       am    = AM_ACC;
  sla_mod_e         nmod  = MOD_NONE;
  logic [1:0]       psel  = 2'h0;
  logic             salt  = 1'b0;
  logic             dalt  = 1'b0;
  logic [15:0]      sec_w = 16'h0344;
  logic [15:0]      areg  = 16'h0000;
  logic [15:0]      ireg  = 16'h0010;
  logic [3:0]       scnt  = 4'h0;
  logic [3:0]       sv    = 4'h0;
  logic             xm    = 1'b0;
  logic [15:0]      rdata = 16'h0000;
  logic             mtag  = 1'b0;
  logic             wen   = 1'b0;
  logic [4:0]       widx  = 5'h00;
  logic [15:0]      wdata = 16'h0000;
  logic [4:0]       ridx  = 5'h00;
  logic             mem_rd, addr_wr, busy, done, ovf, sgn, zf, cf, tag;
  logic [15:0]      mem_addr, addr_wr_data, rd_data, shigh;
  logic [3:0]       ap1;
  int               fails = 0;
  int               num_checks = 0;
  int               cyc, tick = 0;
  logic [15:0]      seen_addr, seen_wr;

  sla_core i_sla_core (
    .MCLK(MCLK), .RST(RST), .START(start), .OP(op), .AMODE(am), .NEXT_MOD(nmod), .PTR_SEL(psel),
    .SRC_ALT(salt), .DST_ALT(dalt), .SECOND_WORD(sec_w), .ADDR_REG(areg), .INDEX_REG(ireg),
    .STRING_COUNT(scnt), .SHIFT_AMOUNT_REG(sv), .SIGN_EXTEND_MODE_BIT(xm), .MEM_RD(mem_rd),
    .MEM_ADDR(mem_addr), .MEM_RDATA(rdata), .MEM_TAG(mtag), .ADDR_WR(addr_wr), .ADDR_WR_DATA(addr_wr_data),
    .ACC_WR_EN(wen), .ACC_WR_IDX(widx), .ACC_WR_DATA(wdata), .ACC_RD_IDX(ridx), .ACC_RD_DATA(rd_data),
    .ACCUM_POINTER_ONE(ap1), .BUSY(busy), .DONE(done), .SHIFT_HIGH_REG(shigh), .OVERFLOW_FLAG(ovf),
    .SIGN_FLAG(sgn), .ZERO_FLAG(zf), .CARRY_FLAG(cf), .TAG_FLAG(tag)
  );

  always #2.5 MCLK = ~MCLK;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (fails == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge MCLK) begin
    tick++;
    if (tick == 3000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge MCLK);
    wen   <= 1'b1;
    widx  <= i;
    wdata <= d;
    @(posedge MCLK);
    wen   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] i, input logic [15:0] exp);
    @(posedge MCLK);
    ridx <= i;
    #1;
    chk("acc", exp, rd_data);
  endtask : rd

  task automatic flags(input logic [3:0] exp);
    chk("flags", {12'h000, exp}, {12'h000, ovf, sgn, zf, cf});
  endtask : flags

  // Issues one instruction and follows it to its done pulse, noting address traffic
  task automatic do_op(input sla_op_e o, input sla_amode_e a, input sla_mod_e m, input logic [1:0] p,
                       input logic sa, input logic da, input logic [3:0] s, input logic x, input logic [3:0] n);
    @(posedge MCLK);
    op    <= o;
    am    <= a;
    nmod  <= m;
    psel  <= p;
    salt  <= sa;
    dalt  <= da;
    sv    <= s;
    xm    <= x;
    scnt  <= n;
    start <= 1'b1;
    @(posedge MCLK);
    start <= 1'b0;
    cyc = 0;
    seen_addr = 16'h0000;
    seen_wr = 16'h0000;
    // Look just past each edge, the take edge too, so the one-cycle fetch strobe is not missed
    #1;
    chk("busy", 16'h0001, {15'h0000, busy});
    while (done !== 1'b1 && cyc < 40) begin
      if (mem_rd === 1'b1) seen_addr = mem_addr;
      @(posedge MCLK);
      #1;
      cyc++;
    end
    if (addr_wr === 1'b1) seen_wr = addr_wr_data;
    chk("done", 16'h0001, {15'h0000, done});
  endtask : do_op

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_add_word();
    wr(5'h01, 16'h8001);
    wr(5'h11, 16'h7ff8);
    do_op(OP_ADD_WORD, AM_ACC, MOD_INC, 2'h1, 1'b0, 1'b1, 4'h4, 1'b1, 4'h0);
    chk("pointer", 16'h0001, {12'h000, ap1});
    chk("cycles", 16'h0003, cyc[15:0]);
    chk("high", 16'hfff8, shigh);
    rd(5'h11, 16'h8008);
    flags(4'b1100);
    wr(5'h02, 16'h8001);
    wr(5'h12, 16'h0000);
    do_op(OP_ADD_WORD, AM_ACC, MOD_INC, 2'h1, 1'b0, 1'b1, 4'h4, 1'b0, 4'h0);
    chk("high", 16'h0008, shigh);
    rd(5'h12, 16'h0010);
    do_op(OP_ADD_WORD, AM_ACC, MOD_DEC, 2'h1, 1'b0, 1'b1, 4'h0, 1'b0, 4'h0);
    chk("pointer", 16'h0001, {12'h000, ap1});
    chk("high", 16'h0000, shigh);
    rd(5'h11, 16'h0009);
    flags(4'b1001);
  endtask : t_add_word

  task automatic t_mem();
    sla_amode_e  ams[3] = '{AM_DIRECT, AM_LONG_REL, AM_POST_ADD};
    logic [15:0] exa[3] = '{16'h0344, 16'h0544, 16'h0200};
    wr(5'h00, 16'h0005);
    @(posedge MCLK);
    areg  <= 16'h0100;
    rdata <= 16'h0003;
    mtag  <= 1'b1;
    do_op(OP_SUB_WORD, AM_POST_INC, MOD_NONE, 2'h0, 1'b0, 1'b0, 4'h1, 1'b0, 4'h0);
    chk("mem_addr", 16'h0100, seen_addr);
    chk("addr_wr", 16'h0102, seen_wr);
    chk("tag", 16'h0001, {15'h0000, tag});
    chk("high", 16'h0000, shigh);
    rd(5'h00, 16'hffff);
    flags(4'b0100);
    @(posedge MCLK);
    areg <= 16'h0200;
    mtag <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      do_op(OP_SUB_WORD, ams[k], MOD_NONE, 2'h0, 1'b0, 1'b0, 4'h1, 1'b0, 4'h0);
      chk("mem_addr", exa[k], seen_addr);
      chk("tag", 16'h0000, {15'h0000, tag});
    end
    chk("addr_wr", 16'h0210, seen_wr);
  endtask : t_mem

  task automatic t_string();
    wr(5'h00, 16'h8001);
    wr(5'h01, 16'h0001);
    wr(5'h10, 16'hfff0);
    wr(5'h11, 16'h0001);
    wr(5'h12, 16'h1234);
    do_op(OP_ADD_STR, AM_ACC, MOD_NONE, 2'h3, 1'b0, 1'b1, 4'h4, 1'b0, 4'h0);
    chk("cycles", 16'h0005, cyc[15:0]);
    rd(5'h10, 16'h0000);
    rd(5'h11, 16'h001a);
    rd(5'h12, 16'h1234);
    chk("high", 16'h0000, shigh);
    flags(4'b0000);
    do_op(OP_SUB_STR, AM_ACC, MOD_NONE, 2'h3, 1'b0, 1'b1, 4'h4, 1'b0, 4'h0);
    rd(5'h10, 16'hfff0);
    rd(5'h11, 16'h0001);
    flags(4'b0001);
  endtask : t_string

  task automatic t_prod();
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h0000);
    wr(5'h02, 16'h8000);
    do_op(OP_STR_PROD, AM_ACC, MOD_NONE, 2'h3, 1'b0, 1'b0, 4'h1, 1'b1, 4'h1);
    chk("cycles", 16'h0007, cyc[15:0]);
    chk("high", 16'hffff, shigh);
    rd(5'h02, 16'h8000);
    flags(4'b0011);
  endtask : t_prod

  task automatic t_zero_shift();
    wr(5'h00, 16'h9abc);
    wr(5'h10, 16'h0000);
    do_op(OP_ADD_WORD, AM_ACC, MOD_NONE, 2'h2, 1'b0, 1'b1, 4'h0, 1'b1, 4'h0);
    chk("high", 16'hffff, shigh);
    rd(5'h10, 16'h9abc);
  endtask : t_zero_shift

  initial begin
    repeat (4) @(posedge MCLK);
    RST <= 1'b0;
    t_add_word();
    t_mem();
    t_string();
    t_prod();
    t_zero_shift();
    end_sim();
  end
endmodule : sla_core_test
